// File: rtl/dfs_supervisor.sv
// Drive fault supervisor: latches errors 00-11, cuts motor power, shows the code.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Pending error shows F and two digits, one each second
// - Any error 00-11 removes motor power at once
// - Supply monitor out of limits raises 01
// - Lost mains phase raises 02 on three-phase only
// - Cable test at first enable raises 03
// - DC link above 480 V raises 04
// - Current above 2.5x rated raises 05
// - Ballast overload raises 06
// - Amplifier overtemperature raises 07
// - Motor overtemperature raises 08
// - Encoder breakage or init failure raises 09
// - Speed above 1.25x maximum raises 10
// - Transient current overrange raises 11
// - Locked fault reports malfunction state F
// - Successful acknowledge enters switch-on inhibit state 1
module dfs_supervisor #(
  parameter int unsigned REFRESH_CYCLES = dfs_pkg::REFRESH_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire dfs_pkg::dfs_monitor_t monitor,
  input  wire logic                  three_phase,
  input  wire logic                  init_done,
  input  wire logic                  enable_req,
  input  wire logic                  ack_req,
  output logic                       motor_power_on,
  output logic                       error_pending,
  output logic [3:0]                 error_code,
  output logic [3:0]                 drive_state,
  output dfs_pkg::dfs_display_t      display
);

  // Monitor inputs after two flip-flops.
  dfs_pkg::dfs_monitor_t mon_s;
  // Synchronised control levels: three-phase strap, init done, enable, ack.
  logic [3:0]            ctl_s;
  // Per-code raw condition, bit n for error n.
  logic [11:0]           cond;
  // Latched errors.
  logic [11:0]           latched;
  logic [11:0]           next_latched;
  // Drive state machine.
  dfs_pkg::dfs_drive_state_t state;
  dfs_pkg::dfs_drive_state_t next_state;
  // Set once the drive has been enabled the first time.
  logic                  first_done;
  logic                  next_first_done;
  // Cable test window: the single cycle of the first enable.
  logic                  cable_test;
  // Acknowledge edge detection on the synchronised level.
  logic                  ack_prev;
  logic                  next_ack_prev;
  logic                  ack_pulse;
  // Lowest latched code and the captured code on display.
  logic [3:0]            low_code;
  logic [3:0]            shown_code;
  logic [3:0]            next_shown_code;
  // Refresh timer and display phase.
  logic [26:0]           tick_cnt;
  logic [26:0]           next_tick_cnt;
  logic [1:0]            phase;
  logic [1:0]            next_phase;
  // Display register.
  dfs_pkg::dfs_display_t next_display;
  // Decoded digits.
  logic [6:0]            seg_tens;
  logic [6:0]            seg_units;
  logic [3:0]            tens_digit;
  logic [3:0]            units_digit;

  // Monitors come straight from comparators, so they are synchronised first.
  // The two-cycle delay is small next to the filter times of the analog monitors.
  dfs_sync #(
    .WIDTH ($bits(dfs_pkg::dfs_monitor_t))
  ) u_sync_mon (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (monitor),
    .sync_out (mon_s)
  );

  // Host levels arrive from another board, so they are synchronised as well.
  dfs_sync #(
    .WIDTH (4)
  ) u_sync_ctl (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({three_phase, init_done, enable_req, ack_req}),
    .sync_out (ctl_s)
  );

  // The cable check happens on each enable from inhibit until the first one after power-up succeeds.
  assign cable_test = (state == dfs_pkg::DRV_INHIBIT) && ctl_s[1] && !first_done;

  // Map every monitor onto its error number.
  // The trip levels themselves (480 V, 2.5x rated current, 1.25x maximum speed) are set
  // in the analog comparators; only their digital verdicts arrive on these inputs.
  always_comb begin
    cond = '0;
    cond[dfs_pkg::ERR_HW]       = mon_s.hw_defect;
    cond[dfs_pkg::ERR_SUPPLY]   = mon_s.supply_out_of_limits;
    cond[dfs_pkg::ERR_PHASE]    = mon_s.phase_lost && ctl_s[3];
    cond[dfs_pkg::ERR_CABLE]    = mon_s.cable_broken && cable_test;
    cond[dfs_pkg::ERR_DC_OV]    = mon_s.dc_link_over;
    cond[dfs_pkg::ERR_OVERCUR]  = mon_s.overcurrent;
    cond[dfs_pkg::ERR_BALLAST]  = mon_s.ballast_overload;
    cond[dfs_pkg::ERR_AMP_TEMP] = mon_s.amp_overtemp;
    cond[dfs_pkg::ERR_MOT_TEMP] = mon_s.motor_overtemp;
    cond[dfs_pkg::ERR_ENCODER]  = mon_s.encoder_line_broken
                                  || mon_s.encoder_init_failed;
    cond[dfs_pkg::ERR_OVERSPD]  = mon_s.overspeed;
    cond[dfs_pkg::ERR_TRANSCUR] = mon_s.current_overrange;
  end

  // One acknowledge per rising edge, so a held level cannot clear repeatedly.
  // The edge register resets low like the idle pin, so reset makes no false edge.
  assign ack_pulse = ctl_s[0] && !ack_prev;

  // Error latches: set wins over acknowledge, and a live condition is never cleared.
  always_comb begin
    next_ack_prev = ctl_s[0];
    for (int i = 0; i < int'(dfs_pkg::NUM_ERR); i++) begin
      if (cond[i]) begin
        next_latched[i] = 1'b1;
      end else if (ack_pulse && state == dfs_pkg::DRV_FAULT
                   && i != int'(dfs_pkg::ERR_HW) && i != int'(dfs_pkg::ERR_SUPPLY)) begin
        next_latched[i] = 1'b0;
      end else begin
        next_latched[i] = latched[i];
      end
    end
  end

  // Drive sequencing: fault lock, acknowledge into inhibit, enable from inhibit.
  always_comb begin
    next_state      = state;
    next_first_done = first_done;
    case (state)
      dfs_pkg::DRV_NOT_READY: begin
        if (|next_latched) begin
          next_state = dfs_pkg::DRV_FAULT;
        end else if (ctl_s[2]) begin
          next_state = dfs_pkg::DRV_INHIBIT;
        end
      end
      dfs_pkg::DRV_INHIBIT: begin
        // A failed cable test leaves first_done clear, so the next enable tests again.
        if (|next_latched) begin
          next_state = dfs_pkg::DRV_FAULT;
        end else if (ctl_s[1]) begin
          next_state      = dfs_pkg::DRV_ENABLED;
          next_first_done = 1'b1;
        end
      end
      dfs_pkg::DRV_ENABLED: begin
        if (|next_latched) begin
          next_state = dfs_pkg::DRV_FAULT;
        end else if (!ctl_s[1]) begin
          next_state = dfs_pkg::DRV_INHIBIT;
        end
      end
      dfs_pkg::DRV_FAULT: begin
        if (!(|next_latched)) begin
          next_state = dfs_pkg::DRV_INHIBIT;
        end
      end
      default: next_state = dfs_pkg::DRV_NOT_READY;
    endcase
  end

  // Register the latches and the state machine.
  // Reset is the only way out for errors 00 and 01; it stands for a power cycle.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      latched    <= '0;
      state      <= dfs_pkg::DRV_NOT_READY;
      first_done <= 1'b0;
      ack_prev   <= 1'b0;
    end else begin
      latched    <= next_latched;
      state      <= next_state;
      first_done <= next_first_done;
      ack_prev   <= next_ack_prev;
    end
  end

  // Power is cut combinationally the same cycle a condition is seen; no ramp.
  // Gating on the live condition as well saves the cycle that the latch would take.
  assign motor_power_on = (state == dfs_pkg::DRV_ENABLED) && !(|latched)
                          && !(|cond);

  // Pending follows the latches alone, so it stays up after the condition has gone.
  assign error_pending = |latched;

  // Report the drive state value; a fault lock reads as F.
  always_comb begin
    case (state)
      dfs_pkg::DRV_NOT_READY: drive_state = dfs_pkg::STATE_NOT_READY;
      dfs_pkg::DRV_INHIBIT:   drive_state = dfs_pkg::STATE_INHIBIT;
      dfs_pkg::DRV_ENABLED:   drive_state = dfs_pkg::STATE_ENABLED;
      dfs_pkg::DRV_FAULT:     drive_state = dfs_pkg::STATE_FAULT;
      default:                drive_state = dfs_pkg::STATE_NOT_READY;
    endcase
  end

  // Lowest-numbered error is the one shown; lower codes are more severe.
  // It is taken from the coming latch value, so the code register catches the first
  // error on the very edge that latches it instead of waiting a whole refresh.
  always_comb begin
    low_code = 4'h0;
    for (int i = int'(dfs_pkg::NUM_ERR) - 1; i >= 0; i--) begin
      if (next_latched[i]) begin
        low_code = 4'(i);
      end
    end
  end

  // Refresh timer: each second steps letter, tens, units; the code is recaptured on the step back to the letter.
  // The timer rests at zero while nothing is pending, so each new error starts on F.
  always_comb begin
    next_tick_cnt   = tick_cnt + 27'h1;
    next_phase      = phase;
    next_shown_code = shown_code;
    if (!(|latched)) begin
      next_tick_cnt   = '0;
      next_phase      = dfs_pkg::PH_LETTER;
      next_shown_code = low_code;
    end else if (tick_cnt >= 27'(REFRESH_CYCLES - 1)) begin
      next_tick_cnt = '0;
      if (phase == dfs_pkg::PH_UNITS) begin
        next_phase      = dfs_pkg::PH_LETTER;
        next_shown_code = low_code;
      end else begin
        next_phase = phase + 2'h1;
      end
    end
  end

  // Split the shown code into two decimal digits.
  assign tens_digit  = (shown_code >= 4'ha) ? 4'h1 : 4'h0;
  assign units_digit = (shown_code >= 4'ha) ? shown_code - 4'ha : shown_code;

  // One decoder per digit; sharing one would need a mux on its input instead.
  dfs_seg_decode u_dec_tens (
    .digit (tens_digit),
    .seg   (seg_tens)
  );

  // Units digit decoder.
  dfs_seg_decode u_dec_units (
    .digit (units_digit),
    .seg   (seg_units)
  );

  // Choose the pattern for the present phase; digits carry the dot as shown.
  // The coming phase is used, so the pattern changes on the edge the timer wraps.
  always_comb begin
    next_display.seg = dfs_pkg::SEG_BLANK;
    next_display.dot = 1'b0;
    if (|latched) begin
      case (next_phase)
        dfs_pkg::PH_LETTER: next_display.seg = dfs_pkg::SEG_F;
        dfs_pkg::PH_TENS: begin
          next_display.seg = seg_tens;
          next_display.dot = 1'b1;
        end
        dfs_pkg::PH_UNITS: begin
          next_display.seg = seg_units;
          next_display.dot = 1'b1;
        end
        default: next_display.seg = dfs_pkg::SEG_BLANK;
      endcase
    end
  end

  // Register timer, phase, code and display.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt   <= '0;
      phase      <= dfs_pkg::PH_LETTER;
      shown_code <= 4'h0;
      display    <= '0;
    end else begin
      tick_cnt   <= next_tick_cnt;
      phase      <= next_phase;
      shown_code <= next_shown_code;
      display    <= next_display;
    end
  end

  // The code output is the captured code, so it never changes within a refresh.
  // One cycle after the latches clear it reads zero, which only has meaning while pending.
  assign error_code = shown_code;

endmodule
`default_nettype wire

// File: rtl/dfs_pkg.sv
// Shared types and constants for the drive fault supervisor.
package dfs_pkg;

  // Number of supervised error codes, 00 through 11.
  localparam int unsigned NUM_ERR = 12;

  // Error code numbers.
  localparam logic [3:0] ERR_HW       = 4'h0;
  localparam logic [3:0] ERR_SUPPLY   = 4'h1;
  localparam logic [3:0] ERR_PHASE    = 4'h2;
  localparam logic [3:0] ERR_CABLE    = 4'h3;
  localparam logic [3:0] ERR_DC_OV    = 4'h4;
  localparam logic [3:0] ERR_OVERCUR  = 4'h5;
  localparam logic [3:0] ERR_BALLAST  = 4'h6;
  localparam logic [3:0] ERR_AMP_TEMP = 4'h7;
  localparam logic [3:0] ERR_MOT_TEMP = 4'h8;
  localparam logic [3:0] ERR_ENCODER  = 4'h9;
  localparam logic [3:0] ERR_OVERSPD  = 4'ha;
  localparam logic [3:0] ERR_TRANSCUR = 4'hb;

  // Drive state values shown on the state output.
  localparam logic [3:0] STATE_NOT_READY = 4'h0;
  localparam logic [3:0] STATE_INHIBIT   = 4'h1;
  localparam logic [3:0] STATE_ENABLED   = 4'h4;
  localparam logic [3:0] STATE_FAULT     = 4'hf;

  // Documented limits, kept for reference by the comparator thresholds.
  localparam int unsigned DC_LINK_MAX_V    = 480;
  localparam int unsigned OVERCUR_X10      = 25;
  localparam int unsigned OVERSPD_X100     = 125;

  // Display refresh: one second at 100 MHz.
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned REFRESH_MS       = 1000;
  localparam int unsigned REFRESH_CYCLES   = CLK_HZ / 1000 * REFRESH_MS;

  // Display phases within one refresh: letter, tens digit, units digit.
  localparam logic [1:0] PH_LETTER = 2'h0;
  localparam logic [1:0] PH_TENS   = 2'h1;
  localparam logic [1:0] PH_UNITS  = 2'h2;

  // Seven-segment patterns, segments g..a in bits 6..0, active high.
  localparam logic [6:0] SEG_F     = 7'h71;
  localparam logic [6:0] SEG_BLANK = 7'h00;

  // Raw fault monitor inputs, all active high comparator levels.
  typedef struct packed {
    logic hw_defect;
    logic supply_out_of_limits;
    logic phase_lost;
    logic cable_broken;
    logic dc_link_over;
    logic overcurrent;
    logic ballast_overload;
    logic amp_overtemp;
    logic motor_overtemp;
    logic encoder_line_broken;
    logic encoder_init_failed;
    logic overspeed;
    logic current_overrange;
  } dfs_monitor_t;

  // Display drive: segment pattern and decimal point.
  typedef struct packed {
    logic [6:0] seg;
    logic       dot;
  } dfs_display_t;

  // Drive sequencing states.
  typedef enum logic [1:0] {
    DRV_NOT_READY,
    DRV_INHIBIT,
    DRV_ENABLED,
    DRV_FAULT
  } dfs_drive_state_t;

endpackage

// File: rtl/dfs_sync.sv
// Two-stage synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module dfs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta;
  // Next values for both stages.
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // Shift the level one stage per clock.
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  // Both stages clear to zero so no fault is seen during reset.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule
`default_nettype wire

// File: rtl/dfs_seg_decode.sv
// Seven-segment decoder for one decimal digit.
`timescale 1ns/1ps
`default_nettype none
module dfs_seg_decode (
  input  wire logic [3:0] digit,
  output logic      [6:0] seg
);

  // Segments g..a, active high; values above nine show blank.
  always_comb begin
    case (digit)
      4'h0:    seg = 7'h3f;
      4'h1:    seg = 7'h06;
      4'h2:    seg = 7'h5b;
      4'h3:    seg = 7'h4f;
      4'h4:    seg = 7'h66;
      4'h5:    seg = 7'h6d;
      4'h6:    seg = 7'h7d;
      4'h7:    seg = 7'h07;
      4'h8:    seg = 7'h7f;
      4'h9:    seg = 7'h6f;
      default: seg = 7'h00;
    endcase
  end

endmodule
`default_nettype wire

// File: sim/dfs_supervisor_assertions.sv
// Concurrent checks on the ports of the drive fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module dfs_supervisor_assertions #(
  parameter int unsigned REFRESH_CYCLES = 8
) (
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire dfs_pkg::dfs_monitor_t monitor,
  input wire logic                  three_phase,
  input wire logic                  init_done,
  input wire logic                  enable_req,
  input wire logic                  ack_req,
  input wire logic                  motor_power_on,
  input wire logic                  error_pending,
  input wire logic [3:0]            error_code,
  input wire logic [3:0]            drive_state,
  input wire dfs_pkg::dfs_display_t display
);
  // All checks share the one clock and are quiet during reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  power_cut_a: assert property (error_pending |-> !motor_power_on)
    else $error("Motor power on while an error is pending");
  dc_trip_a: assert property (monitor.dc_link_over |-> ##[1:3] !motor_power_on)
    else $error("DC link overvoltage did not cut motor power");
  fault_state_a: assert property (error_pending |-> drive_state == dfs_pkg::STATE_FAULT)
    else $error("Drive state is not malfunction while an error is pending");
  show_letter_a: assert property ($rose(error_pending) |-> ##[0:2]
    display.seg == dfs_pkg::SEG_F)
    else $error("Letter F not shown when an error arose");
  sticky_low_a: assert property (error_pending && error_code <= 4'h1 |=> error_pending)
    else $error("Error 00 or 01 was cleared");
  ack_clear_a: assert property ($fell(error_pending) |-> $past(ack_req, 2))
    else $error("Error cleared without an acknowledge");
  inhibit_after_a: assert property ($fell(error_pending) |->
    drive_state == dfs_pkg::STATE_INHIBIT)
    else $error("Acknowledge did not lead to switch-on inhibit");
  supply_trip_a: assert property (monitor.supply_out_of_limits |-> ##[1:3] error_pending)
    else $error("Supply fault did not raise an error");
endmodule
`default_nettype wire

// File: sim/dfs_host_model.sv
// Host controller model that issues enable and acknowledge levels.
`timescale 1ns/1ps
`default_nettype none
module dfs_host_model (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic want_en,
  input  wire logic want_ack,
  output logic      enable_req,
  output logic      ack_req
);
  // Requests change just after an edge and then hold as levels, as a real host would.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enable_req <= 1'b0;
      ack_req    <= 1'b0;
    end else begin
      enable_req <= want_en;
      ack_req    <= want_ack;
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking testbench for the drive fault supervisor.
`timescale 1ns/1ps
`default_nettype none
bind dfs_supervisor dfs_supervisor_assertions #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .monitor(monitor), .three_phase(three_phase),
  .init_done(init_done), .enable_req(enable_req), .ack_req(ack_req),
  .motor_power_on(motor_power_on), .error_pending(error_pending),
  .error_code(error_code), .drive_state(drive_state), .display(display));
module testbench;
  localparam int unsigned REFRESH = 8; // A short refresh keeps the display test brief.
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  dfs_pkg::dfs_monitor_t monitor = '0;
  logic                  three_phase = 1'b1;
  logic                  init_done = 1'b0;
  logic                  want_en = 1'b0;
  logic                  want_ack = 1'b0;
  logic                  enable_req;
  logic                  ack_req;
  logic                  motor_power_on;
  logic                  error_pending;
  logic [3:0]            error_code;
  logic [3:0]            drive_state;
  dfs_pkg::dfs_display_t display;
  int                    num_errors = 0;
  int                    cmp_count = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clock = ~clock;

  dfs_host_model host (.clock(clock), .sys_rst(sys_rst), .want_en(want_en),
    .want_ack(want_ack), .enable_req(enable_req), .ack_req(ack_req));
  dfs_supervisor #(.REFRESH_CYCLES(REFRESH)) dut (.clock(clock), .sys_rst(sys_rst),
    .monitor(monitor), .three_phase(three_phase), .init_done(init_done),
    .enable_req(enable_req), .ack_req(ack_req), .motor_power_on(motor_power_on),
    .error_pending(error_pending), .error_code(error_code),
    .drive_state(drive_state), .display(display));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Compares with case equality so that an unknown never passes.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The acknowledge level is held long enough to cross the synchroniser.
  task automatic ack();
    want_ack <= 1'b1;
    cyc(6);
    want_ack <= 1'b0;
    cyc(3);
  endtask

  task automatic go_enable();
    want_en <= 1'b1;
    cyc(5);
    chk(drive_state, dfs_pkg::STATE_ENABLED);
    chk(motor_power_on, 1'b1);
  endtask

  // Removes every condition first, since an acknowledge on a live one is refused.
  task automatic recover();
    monitor <= '0;
    want_en <= 1'b0;
    cyc(3);
    ack();
    chk(error_pending, 1'b0);
    chk(drive_state, dfs_pkg::STATE_INHIBIT);
  endtask

  task automatic t_init();
    chk(drive_state, dfs_pkg::STATE_NOT_READY);
    init_done <= 1'b1;
    cyc(4);
    chk(drive_state, dfs_pkg::STATE_INHIBIT);
    $display("Test init done");
  endtask

  // A broken cable is only found by the test at the first enable.
  task automatic t_cable();
    monitor.cable_broken <= 1'b1;
    cyc(5);
    chk(error_pending, 1'b0);
    want_en <= 1'b1;
    cyc(6);
    chk(error_code, dfs_pkg::ERR_CABLE);
    chk(motor_power_on, 1'b0);
    recover();
    $display("Test cable done");
  endtask

  // Bit b of the monitor maps to its code; both encoder bits give code 9.
  task automatic t_faults();
    logic [3:0] code;
    for (int b = 10; b >= 0; b--) begin
      if (b == 9) continue;
      code = (b >= 3) ? 4'(12 - b) : 4'(11 - b);
      go_enable();
      monitor[b] <= 1'b1;
      cyc(5);
      chk(motor_power_on, 1'b0);
      chk(error_code, code);
      chk(drive_state, dfs_pkg::STATE_FAULT);
      ack();
      chk(error_pending, 1'b1);
      recover();
    end
    $display("Test fault codes done");
  endtask

  task automatic t_phase();
    three_phase <= 1'b0;
    go_enable();
    monitor.phase_lost <= 1'b1;
    cyc(6);
    chk(error_pending, 1'b0);
    chk(motor_power_on, 1'b1);
    monitor <= '0;
    want_en <= 1'b0;
    three_phase <= 1'b1;
    cyc(3);
    $display("Test single phase done");
  endtask

  // Two faults at once show the lower code; the indicator steps F, tens, units.
  task automatic t_display();
    go_enable();
    monitor.overspeed <= 1'b1;
    monitor.overcurrent <= 1'b1;
    cyc(5);
    chk(error_code, dfs_pkg::ERR_OVERCUR);
    chk(display.seg, dfs_pkg::SEG_F);
    cyc(REFRESH);
    chk(display.seg == dfs_pkg::SEG_F, 1'b0);
    chk({display.seg, display.dot}, {7'h3f, 1'b1});
    cyc(REFRESH);
    chk({display.seg, display.dot}, {7'h6d, 1'b1});
    cyc(REFRESH);
    chk(display.seg, dfs_pkg::SEG_F);
    recover();
    $display("Test display done");
  endtask

  // Codes 00 and 01 survive an acknowledge and go only with a reset.
  task automatic t_sticky();
    for (int k = 0; k < 2; k++) begin
      monitor[12 - k] <= 1'b1;
      cyc(5);
      chk(error_code, 4'(k));
      chk(motor_power_on, 1'b0);
      monitor <= '0;
      cyc(3);
      ack();
      chk(error_pending, 1'b1);
      sys_rst <= 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      cyc(4);
      chk(error_pending, 1'b0);
    end
    $display("Test sticky codes done");
  endtask

  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    t_init();
    t_cable();
    t_faults();
    t_phase();
    t_display();
    t_sticky();
    test_done();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("Error at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
